// ---- verilog/pdl_pkg.sv ----
// Function
// - Send 28 bits over four lanes, seven each.
// - Forward a framing clock beside the data lanes.
// - Edge select high samples rising, low falling.
// - Power-down low puts every lane in high impedance.
// - Clock lane free-runs while the input clock stalls.
`default_nettype none
package pdl_pkg;
   localparam int          WORD_W      = 28;
   localparam int          LANES       = 4;
   localparam int          SLOTS       = 7;
   localparam int          SYNC_W      = 3;
   localparam logic [2:0]  SLOT_LAST   = 3'h6;
   localparam logic [2:0]  SLOT_FIRST  = 3'h0;
   localparam logic [6:0]  CLK_PATTERN = 7'h63;
   localparam int          REF_CLK_MHZ = 20;
   localparam int          STRB_MIN_MHZ = 20;
   localparam int          STRB_MAX_MHZ = 85;
   localparam int          IDLE_TIME_NS = 1000;
   localparam int          IDLE_CYCLES  = (IDLE_TIME_NS * REF_CLK_MHZ + 999) / 1000;
   localparam logic [7:0]  IDLE_LIMIT   = 8'(IDLE_CYCLES);

   typedef logic [WORD_W-1:0] pdl_word_t;

   typedef struct packed {
      logic [LANES-1:0] data;
      logic             clk;
   } pdl_lane_s;
endpackage
`default_nettype wire

// ---- verilog/pdl_serializer.sv ----
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; the output follows once stages two and three agree.
module pdl_sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk_i,      // Destination clock.
   input  wire logic         rstn_i,     // Asynchronous reset, active low.
   input  wire logic [W-1:0] d_i,        // Asynchronous input.
   output logic      [W-1:0] q_o         // Filtered synchronised value.
);
   logic [W-1:0] s1, s2, s3, q;
   logic [W-1:0] next_q;

   always_comb begin
      next_q = q;
      for (int i = 0; i < W; i++) begin
         if (s2[i] == s3[i]) begin
            next_q[i] = s3[i];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q  <= '0;
      end else begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
         q  <= next_q;
      end
   end

   assign q_o = q;
endmodule // pdl_sync3

module pdl_serializer
   import pdl_pkg::*;
(
   input  wire logic          ref_clk_i,            // Bit clock, 20 MHz.
   input  wire logic          rstn_i,               // Async reset, low.
   input  wire logic          input_strobe_clock_i, // Pixel strobe clock.
   input  wire pdl_pkg::pdl_word_t parallel_pixel_in_i, // Parallel word.
   input  wire logic          strobe_edge_select_i, // 1 rising, 0 falling.
   input  wire logic          power_down_n_i,       // Power-down, low.
   output pdl_pkg::pdl_lane_s serial_lanes_o,       // Data and clock lanes.
   output logic               lanes_oe_n_o,         // Lane enable, low drives.
   output logic               clock_tracking_o      // Words are arriving.
);
   import pdl_pkg::*;

   // Strobe side: one capture per edge, each with its own req/ack toggle.
   pdl_word_t rise_word, fall_word, next_rise_word, next_fall_word;
   logic      rise_req, fall_req, next_rise_req, next_fall_req;
   logic      rise_ack, fall_ack, next_rise_ack, next_fall_ack;
   logic      rise_ack_s, fall_ack_s;

   pdl_sync3 #(.W(1)) u_rise_ack (
      .clk_i  (input_strobe_clock_i),
      .rstn_i (rstn_i),
      .d_i    (rise_ack),
      .q_o    (rise_ack_s)
   );

   pdl_sync3 #(.W(1)) u_fall_ack (
      .clk_i  (~input_strobe_clock_i),
      .rstn_i (rstn_i),
      .d_i    (fall_ack),
      .q_o    (fall_ack_s)
   );

   // A word is taken only when the previous one has been acknowledged.
   always_comb begin
      next_rise_word = rise_word;
      next_rise_req  = rise_req;
      if (strobe_edge_select_i && (rise_req == rise_ack_s)) begin
         next_rise_word = parallel_pixel_in_i;
         next_rise_req  = ~rise_req;
      end
   end

   always_ff @(posedge input_strobe_clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rise_word <= '0;
         rise_req  <= 1'b0;
      end else begin
         rise_word <= next_rise_word;
         rise_req  <= next_rise_req;
      end
   end

   always_comb begin
      next_fall_word = fall_word;
      next_fall_req  = fall_req;
      if (!strobe_edge_select_i && (fall_req == fall_ack_s)) begin
         next_fall_word = parallel_pixel_in_i;
         next_fall_req  = ~fall_req;
      end
   end

   always_ff @(negedge input_strobe_clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fall_word <= '0;
         fall_req  <= 1'b0;
      end else begin
         fall_word <= next_fall_word;
         fall_req  <= next_fall_req;
      end
   end

   // Reference side: requests and power-down pass the synchroniser.
   logic rise_req_s, fall_req_s, pwr_n_s;

   pdl_sync3 #(.W(3)) u_ref_sync (
      .clk_i  (ref_clk_i),
      .rstn_i (rstn_i),
      .d_i    ({rise_req, fall_req, power_down_n_i}),
      .q_o    ({rise_req_s, fall_req_s, pwr_n_s})
   );

   // Two-entry buffer between the crossing and the serialiser.
   pdl_word_t  buf_mem [2];
   pdl_word_t  next_buf_mem [2];
   logic       wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [1:0] count, next_count;
   logic       in_valid, in_ready, out_valid, out_ready;
   pdl_word_t  in_word;
   logic       rise_pend, fall_pend;

   assign rise_pend = (rise_req_s != rise_ack);
   assign fall_pend = (fall_req_s != fall_ack);
   assign in_valid  = rise_pend | fall_pend;
   assign in_word   = rise_pend ? rise_word : fall_word;
   assign in_ready  = (count != 2'h2);
   assign out_valid = (count != 2'h0);

   always_comb begin
      next_buf_mem = buf_mem;
      next_wr_ptr  = wr_ptr;
      next_rd_ptr  = rd_ptr;
      next_count   = count;
      next_rise_ack = rise_ack;
      next_fall_ack = fall_ack;
      if (in_valid && in_ready) begin
         next_buf_mem[wr_ptr] = in_word;
         next_wr_ptr = ~wr_ptr;
         if (rise_pend) begin
            next_rise_ack = ~rise_ack;
         end else begin
            next_fall_ack = ~fall_ack;
         end
      end
      if (out_valid && out_ready) begin
         next_rd_ptr = ~rd_ptr;
      end
      case ({in_valid && in_ready, out_valid && out_ready})
         2'b10:   next_count = count + 2'h1;
         2'b01:   next_count = count - 2'h1;
         default: next_count = count;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         buf_mem[0] <= '0;
         buf_mem[1] <= '0;
         wr_ptr     <= 1'b0;
         rd_ptr     <= 1'b0;
         count      <= 2'h0;
         rise_ack   <= 1'b0;
         fall_ack   <= 1'b0;
      end else begin
         buf_mem    <= next_buf_mem;
         wr_ptr     <= next_wr_ptr;
         rd_ptr     <= next_rd_ptr;
         count      <= next_count;
         rise_ack   <= next_rise_ack;
         fall_ack   <= next_fall_ack;
      end
   end

   // Serialiser: seven slots per word, one bit per lane per slot.
   function automatic logic [LANES-1:0] lane_bits(
      input pdl_word_t  w,
      input logic [2:0] slot
   );
      logic [LANES-1:0] b;
      b = '0;
      for (int k = 0; k < LANES; k++) begin
         b[k] = w[k*SLOTS + int'(SLOT_LAST - slot)];
      end
      return b;
   endfunction

   logic [2:0] slot, next_slot;
   pdl_word_t  cur_word, next_cur_word, sel_word;
   pdl_lane_s  lanes, next_lanes;
   logic       oe_n, next_oe_n;
   logic [7:0] idle_cnt, next_idle_cnt;

   assign out_ready = (slot == SLOT_LAST);

   always_comb begin
      next_slot     = (slot == SLOT_LAST) ? SLOT_FIRST : slot + 3'h1;
      sel_word      = cur_word;
      next_idle_cnt = idle_cnt;
      if (slot == SLOT_LAST) begin
         // An empty buffer yields an all-low word.
         sel_word = out_valid ? buf_mem[rd_ptr] : '0;
      end
      next_cur_word   = sel_word;
      next_lanes.data = lane_bits(sel_word, next_slot);
      // The clock lane runs from the bit clock, so it never stops.
      next_lanes.clk  = CLK_PATTERN[SLOT_LAST - next_slot];
      next_oe_n       = ~pwr_n_s;
      if (in_valid && in_ready) begin
         next_idle_cnt = 8'h00;
      end else if (idle_cnt != IDLE_LIMIT) begin
         next_idle_cnt = idle_cnt + 8'h01;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         slot     <= SLOT_LAST;
         cur_word <= '0;
         lanes    <= '0;
         oe_n     <= 1'b1;
         idle_cnt <= IDLE_LIMIT;
      end else begin
         slot     <= next_slot;
         cur_word <= next_cur_word;
         lanes    <= next_lanes;
         oe_n     <= next_oe_n;
         idle_cnt <= next_idle_cnt;
      end
   end

   assign serial_lanes_o   = lanes;
   assign lanes_oe_n_o     = oe_n;
   assign clock_tracking_o = (idle_cnt != IDLE_LIMIT);
endmodule // pdl_serializer

`default_nettype wire

// ---- tb/pdl_serializer_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module pdl_chk
   import pdl_pkg::*;
(
   input wire logic               ref_clk_i,       // Clock.
   input wire logic               rstn_i,          // Reset.
   input wire logic               power_down_n_i,  // Power-down.
   input wire pdl_pkg::pdl_lane_s serial_lanes_o,  // Lanes.
   input wire logic               lanes_oe_n_o,    // Enable.
   input wire logic               clock_tracking_o // Tracking.
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   a_clk_pattern: assert property ($fell(serial_lanes_o.clk) |-> ##1
      (!serial_lanes_o.clk)[*2] ##1 (serial_lanes_o.clk)[*4] ##1
      !serial_lanes_o.clk) else $error("clock lane pattern");
   a_pd_float: assert property ($fell(power_down_n_i) |-> ##[1:5]
      lanes_oe_n_o) else $error("late high impedance");
   a_pd_hold: assert property ((!power_down_n_i)[*6] |-> lanes_oe_n_o)
      else $error("driven in power-down");
   a_wake_drive: assert property (power_down_n_i[*8] |-> !lanes_oe_n_o)
      else $error("not driven when awake");
   a_idle_low: assert property ((!clock_tracking_o)[*8] |->
      serial_lanes_o.data == 4'h0) else $error("idle lanes not low");
   a_free_run: assert property ((!clock_tracking_o)[*8] |-> ##[1:7]
      $rose(serial_lanes_o.clk)) else $error("clock lane stalled");
   cover property ($fell(power_down_n_i));
   cover property ($rose(clock_tracking_o));
   cover property (serial_lanes_o.data != 4'h0);
endmodule // pdl_chk
`default_nettype wire

// ---- tb/pdl_rx_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pdl_rx_model
   import pdl_pkg::*;
(
   input  wire logic               ref_clk_i,   // Bit clock.
   input  wire logic               rstn_i,      // Reset.
   input  wire pdl_pkg::pdl_lane_s lanes_i,     // Lanes.
   input  wire logic               oe_n_i,      // Lane enable.
   output pdl_pkg::pdl_word_t      word_o,      // Word.
   output logic                    word_valid_o // Word strobe.
);
   logic [3:0] hist;
   logic [6:0] sh [LANES];
   logic [2:0] cnt;
   // Slot 0 is the only slot whose last four clock bits read 0111.
   always @(posedge ref_clk_i) begin
      word_valid_o <= 1'b0;
      hist <= {hist[2:0], lanes_i.clk};
      if (!rstn_i)
         cnt <= 3'h0;
      else if ({hist[2:0], lanes_i.clk} == 4'h7 && !oe_n_i) begin
         word_valid_o <= (cnt == 3'h7);
         for (int k = 0; k < LANES; k++)
            word_o[7*k +: 7] <= sh[k];
         cnt <= 3'h1;
      end else if (cnt != 3'h7 && cnt != 3'h0)
         cnt <= cnt + 3'h1;
      for (int k = 0; k < LANES; k++)
         sh[k] <= {sh[k][5:0], lanes_i.data[k]};
   end
endmodule // pdl_rx_model
`default_nettype wire

// ---- tb/tb_pdl_serializer.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; \
   $display("[FAIL] %s exp %h got %h", n, e, s); end end
bind pdl_serializer pdl_chk pdl_chk_inst (.ref_clk_i(ref_clk_i),
   .rstn_i(rstn_i), .power_down_n_i(power_down_n_i),
   .serial_lanes_o(serial_lanes_o), .lanes_oe_n_o(lanes_oe_n_o),
   .clock_tracking_o(clock_tracking_o));
module tb_pdl_serializer;
   import pdl_pkg::*;
   logic      ref_clk = 1'b0;
   logic      strb = 1'b0;
   logic      strb_en = 1'b1;
   logic      rstn = 1'b0;
   logic      sel = 1'b1;
   logic      pd_n = 1'b1;
   pdl_word_t din = '0;
   pdl_word_t exp_w = '0;
   pdl_word_t last = '0;
   pdl_word_t rx_word;
   pdl_lane_s lanes;
   logic      oe_n;
   logic      track;
   logic      rx_v;
   int        num_errors = 0;
   int        checks = 0;
   int        cyc = 0;
   int        wrong = 0;
   always #25 ref_clk = ~ref_clk;
   always #62.5 if (strb_en) strb = ~strb;
   pdl_serializer pdl_serializer_inst (.ref_clk_i(ref_clk), .rstn_i(rstn),
      .input_strobe_clock_i(strb), .parallel_pixel_in_i(din),
      .strobe_edge_select_i(sel), .power_down_n_i(pd_n),
      .serial_lanes_o(lanes), .lanes_oe_n_o(oe_n),
      .clock_tracking_o(track));
   pdl_rx_model pdl_rx_model_inst (.ref_clk_i(ref_clk), .rstn_i(rstn),
      .lanes_i(lanes), .oe_n_i(oe_n), .word_o(rx_word), .word_valid_o(rx_v));
   always @(posedge ref_clk) begin
      cyc++;
      if (rx_v === 1'b1 && rx_word !== '0) begin
         last = rx_word;
         if (rx_word !== exp_w)
            wrong++;
      end
      if (cyc == 2000) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Data changes on both edges so only the selected edge yields exp_w.
   task automatic t_edge(input logic s, input pdl_word_t a, pdl_word_t b);
      sel = s;
      exp_w = s ? b : a;
      din = exp_w;
      wrong = 0;
      last = '0;
      strb_en = 1'b1;
      repeat (6) begin
         @(posedge strb) #1 din = a;
         @(negedge strb) #1 din = b;
      end
      `CHK("tracking on", 1'b1, track)
      strb_en = 1'b0;
      repeat (40) @(posedge ref_clk);
      `CHK("last word", exp_w, last)
      `CHK("stray words", 0, wrong)
      $display("edge test %0d done", s);
   endtask
   task automatic t_pd;
      strb_en = 1'b1;
      @(posedge ref_clk) #1 pd_n = 1'b0;
      repeat (6) @(posedge ref_clk);
      #1 `CHK("oe_n down", 1'b1, oe_n)
      pd_n = 1'b1;
      repeat (8) @(posedge ref_clk);
      #1 `CHK("oe_n up", 1'b0, oe_n)
      strb_en = 1'b0;
      $display("power-down test done");
   endtask
   task automatic t_idle;
      int         ones;
      logic [3:0] any;
      ones = 0;
      any = 4'h0;
      din = 'z;
      repeat (40) @(posedge ref_clk);
      repeat (14) begin
         @(posedge ref_clk) #1;
         ones += lanes.clk;
         any |= lanes.data;
      end
      `CHK("idle clk ones", 8, ones)
      `CHK("idle data", 4'h0, any)
      `CHK("tracking off", 1'b0, track)
      $display("idle test done");
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      #1 rstn = 1'b1;
      strb_en = 1'b0;
      repeat (10) @(posedge ref_clk);
      t_edge(1'b1, 28'h1234567, 28'hA5C3E17);
      t_edge(1'b0, 28'h5A3C1E8, 28'hFEDCBA9);
      t_pd();
      t_idle();
      end_of_test();
   end
endmodule // tb_pdl_serializer
`default_nettype wire
